// ==== design/bmm_pkg.sv ====
// Purpose: Shared constants and types for the boot mode and bus master block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Register offsets and field positions are defined here only
//
// Notes on behaviour
// - Boot source select high: boot memory select pin drives EPROM chip select.
// - Multiprocessor system: only the current bus master drives boot memory select.
// - Source select 0, boot memory select low: no boot, run from external memory.
// - Source select 0, boot memory select high: host boot using host width bit.
// - Boot memory select may float only in EPROM mode; otherwise plain input.
// - Reset gives a known state, then execution starts at the reset vector.
// - Bus master indicator high while holding the shared bus, and always with number 00.
// - Multiprocessor number 00: bus master indicator held permanently high; the code holds it low while reset is asserted.
// - Boot source select high: boot image loads from an 8-bit EPROM.
package bmm_pkg;

    localparam int          WB_AW          = 8;
    localparam int          WB_DW          = 32;
    localparam int          VEC_W          = 32;

    // Register byte offsets
    localparam logic [7:0]  CFG_OFS        = 8'h00;
    localparam logic [7:0]  STAT_OFS       = 8'h04;
    localparam logic [7:0]  VEC_OFS        = 8'h08;

    // Configuration register fields
    localparam int          CFG_HOST_W_BIT = 0;
    localparam int          CFG_CS_BIT     = 1;
    localparam int          CFG_FLOAT_BIT  = 2;
    localparam logic [2:0]  CFG_RST        = 3'h0;

    // Status register fields
    localparam int          ST_MODE_LSB    = 0;
    localparam int          ST_PHASE_LSB   = 2;
    localparam int          ST_MASTER_BIT  = 4;
    localparam int          ST_MPN_LSB     = 5;

    localparam logic [1:0]  MPN_SINGLE     = 2'h0;
    localparam logic [3:0]  EPROM_BYTE_W   = 4'h8;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

    typedef enum logic [1:0] {
        BOOT_EPROM,
        BOOT_HOST,
        BOOT_NONE
    } bmm_boot_e;

    typedef enum logic [1:0] {
        PH_RESET,
        PH_START,
        PH_RUN
    } bmm_phase_e;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [3:0]       sel;
        logic [WB_AW-1:0] adr;
        logic [WB_DW-1:0] dat;
    } bmm_wb_req_s;

    typedef struct packed {
        logic             ack;
        logic [WB_DW-1:0] dat;
    } bmm_wb_rsp_s;

    // Boot memory select pin as two signals
    typedef struct packed {
        logic sel_n;
        logic oe_n;
    } bmm_pin_out_s;

endpackage : bmm_pkg

// ==== design/bmm_mode_decode.sv ====
// Purpose: Decode the two boot straps into a boot mode
// Assumes: Straps are steady levels while reset is asserted
// Notes:   Pure decode; the top samples the result during reset
`timescale 1ns/1ns
`default_nettype none
module bmm_mode_decode (
    input  wire logic              src_sel,
    input  wire logic              pin_level,
    output var  bmm_pkg::bmm_boot_e mode
);

    always_comb begin
        if (src_sel) begin
            mode = bmm_pkg::BOOT_EPROM;
        end else if (pin_level) begin
            mode = bmm_pkg::BOOT_HOST;
        end else begin
            mode = bmm_pkg::BOOT_NONE;
        end
    end

endmodule : bmm_mode_decode
`default_nettype wire

// ==== design/bmm_master_ind.sv ====
// Purpose: Registered bus master indicator
// Assumes: Arbiter grant level is synchronous to clock
// Notes:   Number sampled by the top during reset only
`timescale 1ns/1ns
`default_nettype none
module bmm_master_ind (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [1:0] mp_number,
    input  wire logic       holds_bus,
    output var  logic       master_r
);

    typedef struct packed {
        logic master;
    } bmm_mi_s;

    bmm_mi_s st_r;
    bmm_mi_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!rst_n) begin
            st_nxt.master = 1'b0;
        end else if (mp_number == bmm_pkg::MPN_SINGLE) begin
            st_nxt.master = 1'b1;
        end else begin
            st_nxt.master = holds_bus;
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    assign master_r = st_r.master;

endmodule : bmm_master_ind
`default_nettype wire

// ==== design/bmm_top.sv ====
// Purpose: Boot mode selection, reset start-up and bus master indication
// Assumes: Single 10 MHz clock, synchronous active-low reset, Wishbone slave
// Notes:   Straps and multiprocessor number are frozen at reset release
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module bmm_top #(
    parameter logic [31:0] RESET_VECTOR = 32'h0000_1000
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // Register bus
    input  wire bmm_pkg::bmm_wb_req_s wb_req,
    output var  bmm_pkg::bmm_wb_rsp_s wb_rsp,
    // Boot straps and pin
    input  wire logic                 boot_source_select,
    input  wire logic                 boot_memory_select_i,
    output var  bmm_pkg::bmm_pin_out_s boot_memory_select_o,
    // Boot loader chip-select request
    input  wire logic                 boot_fetch_req,
    // Multiprocessing
    input  wire logic [1:0]           multiprocessor_number,
    input  wire logic                 holds_bus,
    output var  logic                 bus_master_indicator,
    // Start-up results
    output var  bmm_pkg::bmm_boot_e   boot_mode,
    output var  logic                 host_width_bit,
    output var  logic [3:0]           eprom_width,
    output var  logic                 fetch_external,
    output var  logic                 exec_start,
    output var  logic [31:0]          exec_addr
);

    typedef struct packed {
        bmm_pkg::bmm_phase_e phase;
        bmm_pkg::bmm_boot_e  mode;
        logic [1:0]          mpn;
        logic [2:0]          cfg;
        logic                ack;
        logic [31:0]         rdat;
        logic                start;
        logic [31:0]         addr;
        logic                host_w;
        logic [3:0]          ewidth;
        logic                fext;
        logic                sel_n;
        logic                oe_n;
    } bmm_top_s;

    bmm_top_s            st_r;
    bmm_top_s            st_nxt;
    bmm_pkg::bmm_boot_e  strap_mode;
    logic                master_r;
    logic                req;
    logic                wr;
    logic                eprom;
    logic                drive_ok;
    logic [31:0]         status;

    bmm_mode_decode u_decode (
        .src_sel   (boot_source_select),
        .pin_level (boot_memory_select_i),
        .mode      (strap_mode)
    );

    // Uses the frozen number so a glitch after reset cannot flip the role
    bmm_master_ind u_master (
        .clock     (clock),
        .rst_n     (rst_n),
        .mp_number (st_r.mpn),
        .holds_bus (holds_bus),
        .master_r  (master_r)
    );

    always_comb begin
        status = bmm_pkg::ZERO_WORD;
        status[bmm_pkg::ST_MODE_LSB +: 2]  = st_r.mode;
        status[bmm_pkg::ST_PHASE_LSB +: 2] = st_r.phase;
        status[bmm_pkg::ST_MASTER_BIT]     = master_r;
        status[bmm_pkg::ST_MPN_LSB +: 2]   = st_r.mpn;
    end

    assign req      = wb_req.cyc & wb_req.stb & ~st_r.ack;
    assign wr       = req & wb_req.we & wb_req.sel[0];
    assign eprom    = (st_r.mode == bmm_pkg::BOOT_EPROM);
    // Only the bus owner may drive the shared chip select
    assign drive_ok = eprom & master_r;

    always_comb begin
        st_nxt = st_r;
        if (!rst_n) begin
            // Known state; straps watched for the whole reset
            st_nxt.phase  = bmm_pkg::PH_RESET;
            st_nxt.mode   = strap_mode;
            st_nxt.mpn    = multiprocessor_number;
            st_nxt.cfg    = bmm_pkg::CFG_RST;
            st_nxt.ack    = 1'b0;
            st_nxt.rdat   = bmm_pkg::ZERO_WORD;
            st_nxt.start  = 1'b0;
            st_nxt.addr   = bmm_pkg::ZERO_WORD;
            st_nxt.host_w = 1'b0;
            st_nxt.ewidth = 4'h0;
            st_nxt.fext   = 1'b0;
            st_nxt.sel_n  = 1'b1;
            st_nxt.oe_n   = 1'b1;
        end else begin
            // Start-up sequence
            st_nxt.start = 1'b0;
            case (st_r.phase)
                bmm_pkg::PH_RESET: begin
                    st_nxt.phase = bmm_pkg::PH_START;
                    st_nxt.start = 1'b1;
                    st_nxt.addr  = RESET_VECTOR;
                end
                bmm_pkg::PH_START: begin
                    st_nxt.phase = bmm_pkg::PH_RUN;
                end
                bmm_pkg::PH_RUN: begin
                    st_nxt.phase = bmm_pkg::PH_RUN;
                end
                default: begin
                    st_nxt.phase = bmm_pkg::PH_RESET;
                end
            endcase

            // Bus slave: one wait state, ack dropped the next cycle
            st_nxt.ack  = req;
            st_nxt.rdat = bmm_pkg::ZERO_WORD;
            if (req && !wb_req.we) begin
                case (wb_req.adr)
                    bmm_pkg::CFG_OFS:  st_nxt.rdat = {29'h0, st_r.cfg};
                    bmm_pkg::STAT_OFS: st_nxt.rdat = status;
                    bmm_pkg::VEC_OFS:  st_nxt.rdat = RESET_VECTOR;
                    default:           st_nxt.rdat = bmm_pkg::ZERO_WORD;
                endcase
            end
            if (wr && wb_req.adr == bmm_pkg::CFG_OFS) begin
                st_nxt.cfg = wb_req.dat[2:0];
            end

            // Mode dependent outputs
            st_nxt.host_w = (st_r.mode == bmm_pkg::BOOT_HOST)
                          & st_r.cfg[bmm_pkg::CFG_HOST_W_BIT];
            st_nxt.ewidth = eprom ? bmm_pkg::EPROM_BYTE_W : 4'h0;
            st_nxt.fext = (st_r.mode == bmm_pkg::BOOT_NONE);

            // Chip select toward EPROM, active low
            st_nxt.sel_n = ~(drive_ok
                           & (boot_fetch_req | st_r.cfg[bmm_pkg::CFG_CS_BIT]));
            // Pin is an input except when driven in EPROM mode
            st_nxt.oe_n  = ~(drive_ok & ~st_r.cfg[bmm_pkg::CFG_FLOAT_BIT]);
        end
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    assign wb_rsp.ack                 = st_r.ack;
    assign wb_rsp.dat                 = st_r.rdat;
    assign boot_memory_select_o.sel_n = st_r.sel_n;
    assign boot_memory_select_o.oe_n  = st_r.oe_n;
    assign bus_master_indicator       = master_r;
    assign boot_mode                  = st_r.mode;
    assign host_width_bit             = st_r.host_w;
    assign eprom_width                = st_r.ewidth;
    assign fetch_external             = st_r.fext;
    assign exec_start                 = st_r.start;
    assign exec_addr                  = st_r.addr;

endmodule : bmm_top
`default_nettype wire

// ==== sim/bmm_monitor.sv ====
// Purpose: Port assertions for the boot mode block
// Assumes: One clock, synchronous active-low reset
// Notes:   Strap copy is taken only in reset, like the block
`timescale 1ns/1ns
`default_nettype none
module bmm_monitor #(
    parameter logic [31:0] RESET_VECTOR = 32'h0000_1000
) (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire bmm_pkg::bmm_wb_req_s  wb_req,
    input wire bmm_pkg::bmm_wb_rsp_s  wb_rsp,
    input wire logic                  boot_source_select,
    input wire logic                  boot_memory_select_i,
    input wire bmm_pkg::bmm_pin_out_s boot_memory_select_o,
    input wire logic                  boot_fetch_req,
    input wire logic [1:0]            multiprocessor_number,
    input wire logic                  holds_bus,
    input wire logic                  bus_master_indicator,
    input wire bmm_pkg::bmm_boot_e    boot_mode,
    input wire logic [3:0]            eprom_width,
    input wire logic                  fetch_external,
    input wire logic                  exec_start,
    input wire logic [31:0]           exec_addr
);
    logic       rst_q;
    logic [1:0] strap_r;
    logic [1:0] mpn_r;
    logic       float_r;
    always_ff @(posedge clock) begin
        rst_q <= rst_n;
        if (!rst_n) begin
            strap_r <= {boot_source_select, boot_memory_select_i};
            mpn_r   <= multiprocessor_number;
            float_r <= 1'b0;
        end else if (wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && wb_rsp.ack
                     && wb_req.adr == bmm_pkg::CFG_OFS) begin
            // Taken at the ack edge, which lines up with the pin's own delay
            float_r <= wb_req.dat[bmm_pkg::CFG_FLOAT_BIT];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    sequence s_ack_pulse;
        wb_rsp.ack ##1 !wb_rsp.ack;
    endsequence
    a_ack_one_pulse: assert property (s_take |=> s_ack_pulse)
        else $error("bus ack not a single pulse");
    a_pin_eprom_only: assert property (boot_mode != bmm_pkg::BOOT_EPROM |->
        boot_memory_select_o.oe_n && boot_memory_select_o.sel_n) else $error("pin driven");
    a_pin_master_only: assert property (!boot_memory_select_o.oe_n |->
        $past(bus_master_indicator)) else $error("pin driven by non-master");
    a_cs_on_fetch: assert property (boot_mode == bmm_pkg::BOOT_EPROM &&
        bus_master_indicator && boot_fetch_req |=> !boot_memory_select_o.sel_n &&
        boot_memory_select_o.oe_n == float_r) else $error("chip select missing");
    a_ind_high: assert property (holds_bus || mpn_r ==
        bmm_pkg::MPN_SINGLE |=> bus_master_indicator) else $error("indicator low");
    a_ind_low: assert property (!holds_bus && mpn_r !=
        bmm_pkg::MPN_SINGLE |=> !bus_master_indicator) else $error("indicator high");
    a_start_vector: assert property (rst_n && !rst_q |=> exec_start &&
        exec_addr == RESET_VECTOR ##1 !exec_start) else $error("bad start");
    a_mode_held: assert property (rst_q |-> $stable(boot_mode) &&
        boot_mode == (strap_r[1] ? bmm_pkg::BOOT_EPROM : strap_r[0] ?
        bmm_pkg::BOOT_HOST : bmm_pkg::BOOT_NONE)) else $error("bad boot mode");
    a_mode_outs: assert property (rst_q |-> fetch_external ==
        (boot_mode == bmm_pkg::BOOT_NONE) && eprom_width == (boot_mode ==
        bmm_pkg::BOOT_EPROM ? bmm_pkg::EPROM_BYTE_W : 4'h0)) else $error("bad mode outs");
endmodule : bmm_monitor
bind bmm_top bmm_monitor #(.RESET_VECTOR(RESET_VECTOR)) i_mon (.clock(clock),
    .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .boot_source_select(boot_source_select), .boot_memory_select_i(boot_memory_select_i),
    .boot_memory_select_o(boot_memory_select_o), .boot_fetch_req(boot_fetch_req),
    .multiprocessor_number(multiprocessor_number), .holds_bus(holds_bus),
    .bus_master_indicator(bus_master_indicator), .boot_mode(boot_mode),
    .eprom_width(eprom_width), .fetch_external(fetch_external),
    .exec_start(exec_start), .exec_addr(exec_addr));
`default_nettype wire

// ==== sim/bmm_partner.sv ====
// Purpose: Far side of the boot pin: strap or boot memory select
// Assumes: No pull resistor on the pin in the chip select role
// Notes:   Released pin toggles while source select is high so a stale level never looks valid; otherwise it reads the strap
`timescale 1ns/1ns
`default_nettype none
module bmm_partner (
    input  wire logic                  clock,
    input  wire bmm_pkg::bmm_pin_out_s pin_o,
    input  wire logic                  src_sel,
    input  wire logic                  strap,
    output var  logic                  pin_lvl
);
    logic tgl = 1'b0;
    always_ff @(posedge clock) begin
        tgl <= ~tgl;
    end
    always_comb begin
        if (!pin_o.oe_n) begin
            pin_lvl = pin_o.sel_n;
        end else if (src_sel) begin
            pin_lvl = tgl;
        end else begin
            pin_lvl = strap;
        end
    end
endmodule : bmm_partner
`default_nettype wire

// ==== sim/tb_bmm_top.sv ====
// Purpose: Self-checking bench for the boot mode block
// Assumes: Straps move only while reset is held, but once on purpose
// Notes:   Outputs are read at the edge, before that edge's updates
`timescale 1ns/1ns
`default_nettype none
module tb_bmm_top;
    localparam logic [31:0] VEC = 32'h0000_2040;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic src = 1'b0;
    logic strap = 1'b0;
    logic fetch = 1'b0;
    logic hold = 1'b0;
    logic [1:0] mpn = 2'h0;
    logic pin_lvl, ind, host_w, fext, start;
    logic [3:0] ew;
    logic [31:0] addr, rd;
    bmm_pkg::bmm_wb_req_s wb_req = '0;
    bmm_pkg::bmm_wb_rsp_s wb_rsp;
    bmm_pkg::bmm_pin_out_s pin_o;
    bmm_pkg::bmm_boot_e mode;
    int miscompares = 0;
    int cmp_count = 0;
    always #50 clock = ~clock;
    bmm_top #(.RESET_VECTOR(VEC)) i_dut (.clock(clock), .rst_n(rst_n), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .boot_source_select(src), .boot_memory_select_i(pin_lvl),
        .boot_memory_select_o(pin_o), .boot_fetch_req(fetch), .multiprocessor_number(mpn),
        .holds_bus(hold), .bus_master_indicator(ind), .boot_mode(mode),
        .host_width_bit(host_w), .eprom_width(ew), .fetch_external(fext),
        .exec_start(start), .exec_addr(addr));
    bmm_partner i_far (.clock(clock), .pin_o(pin_o), .src_sel(src), .strap(strap),
        .pin_lvl(pin_lvl));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do begin
            @(posedge clock);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        if (wb_rsp.ack !== 1'b1) miscompares++;
        rd = wb_rsp.dat;
        wb_req <= '0;
        tick(1);
    endtask : wb
    task automatic boot(input logic s, input logic p, input logic [1:0] m,
                        input bmm_pkg::bmm_boot_e e);
        rst_n <= 1'b0;
        src <= s;
        strap <= p;
        mpn <= m;
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        chk("exec_start", 1'b1, start);
        tick(1);
        chk("exec_start", 1'b0, start);
        chk("exec_addr", VEC, addr);
        chk("boot_mode", e, mode);
        chk("fetch_external", e == bmm_pkg::BOOT_NONE, fext);
        chk("eprom_width", e == bmm_pkg::BOOT_EPROM ? 32'h0000_0008 : 32'h0000_0000, ew);
    endtask : boot
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    initial begin
        tick(1);
        boot(1'b0, 1'b0, 2'h2, bmm_pkg::BOOT_NONE);
        chk("indicator", 1'b0, ind);
        hold <= 1'b1;
        tick(3);
        chk("indicator", 1'b1, ind);
        hold <= 1'b0;
        strap <= 1'b1;
        tick(3);
        chk("held mode", bmm_pkg::BOOT_NONE, mode);
        boot(1'b0, 1'b1, 2'h0, bmm_pkg::BOOT_HOST);
        chk("indicator", 1'b1, ind);
        chk("pin", 2'h3, pin_o);
        chk("host width", 1'b0, host_w);
        wb(1'b1, bmm_pkg::CFG_OFS, 32'h0000_0001);
        tick(1);
        chk("host width", 1'b1, host_w);
        wb(1'b0, bmm_pkg::STAT_OFS, 32'h0000_0000);
        chk("status", 32'h0000_0019, rd);
        wb(1'b0, bmm_pkg::VEC_OFS, 32'h0000_0000);
        chk("vector", VEC, rd);
        wb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        boot(1'b1, 1'b0, 2'h1, bmm_pkg::BOOT_EPROM);
        fetch <= 1'b1;
        tick(3);
        chk("pin idle", 2'h3, pin_o);
        hold <= 1'b1;
        tick(3);
        chk("pin drive", 2'h0, pin_o);
        wb(1'b1, bmm_pkg::CFG_OFS, 32'h0000_0004);
        tick(1);
        chk("pin float", 2'h1, pin_o);
        fetch <= 1'b0;
        wb(1'b1, bmm_pkg::CFG_OFS, 32'h0000_0002);
        tick(1);
        chk("pin forced", 2'h0, pin_o);
        hold <= 1'b0;
        tick(3);
        chk("pin release", 2'h3, pin_o);
        fetch <= 1'b0;
        print_verdict;
    end
    initial begin
        tick(2000);
        miscompares++;
        print_verdict;
    end
endmodule : tb_bmm_top
`default_nettype wire
